/* File: logic/xcvr_top.sv */
// Octal registered bidirectional bus transceiver, two independent directions
// Behaviour
// - Two separate 8-bit registers, one per direction
// - Rising capture clock loads source byte
// - Capture enable high ignores clock edges
// - No rising edge keeps stored byte
// - Drive enable low drives stored byte
// - Drive enable high releases destination port
// - Bytes pass through without inversion
// - B to A path mirrors A to B
`timescale 1ns/1ps
module xcvr_top
   import xcvr_pkg::*;
(
   input  wire logic  core_clk_i,
   input  wire logic  nrst_i,
   input  wire logic  a_to_b_capture_clock_i,
   input  wire logic  a_to_b_capture_enable_n_i,
   input  wire logic  a_to_b_drive_enable_n_i,
   input  wire logic  b_to_a_capture_clock_i,
   input  wire logic  b_to_a_capture_enable_n_i,
   input  wire logic  b_to_a_drive_enable_n_i,
   input  wire byte_t port_a_i,
   output byte_t      port_a_o,
   output logic [7:0] port_a_oe_o,
   input  wire byte_t port_b_i,
   output byte_t      port_b_o,
   output logic [7:0] port_b_oe_o,
   output logic       a_to_b_overrun_o,
   output logic       b_to_a_overrun_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Direction 0 is A to B, direction 1 is B to A
   logic  [1:0] clk_pin;
   logic  [1:0] cen_pin;
   logic  [1:0] oe_pin;
   byte_t       src_pin [2];
   byte_t       dst_q [2];
   logic  [1:0] dst_oe;
   logic  [1:0] ovr;

   assign clk_pin    = {b_to_a_capture_clock_i, a_to_b_capture_clock_i};
   assign cen_pin    = {b_to_a_capture_enable_n_i, a_to_b_capture_enable_n_i};
   assign oe_pin     = {b_to_a_drive_enable_n_i, a_to_b_drive_enable_n_i};
   assign src_pin[0] = port_a_i;
   assign src_pin[1] = port_b_i;

   // Agreement of two late stages filters a single-cycle glitch
   function automatic logic agreed(input logic [2:0] s, input logic prev);
      agreed = (s[2] == s[1]) ? s[2] : prev;
   endfunction

   genvar d;
   generate
      for (d = 0; d < 2; d++) begin : g_dir
         // Pin synchronisers, newest sample in bit 0, and filtered levels
         logic [2:0] clk_s_r;
         logic [2:0] clk_s_nxt;
         logic [2:0] cen_s_r;
         logic [2:0] cen_s_nxt;
         logic [2:0] oe_s_r;
         logic [2:0] oe_s_nxt;
         logic       clk_lv_r;
         logic       clk_lv_nxt;
         logic       cen_lv_r;
         logic       cen_lv_nxt;
         logic       oe_lv_r;
         logic       oe_lv_nxt;
         // Source byte, delayed by as many stages as the clock pin
         byte_t      dat_s1_r;
         byte_t      dat_s1_nxt;
         byte_t      dat_s2_r;
         byte_t      dat_s2_nxt;
         byte_t      dat_s3_r;
         byte_t      dat_s3_nxt;
         // Settling guard after reset
         logic [1:0] settle_r;
         logic [1:0] settle_nxt;
         logic       armed_r;
         logic       armed_nxt;
         // Capture strobe, buffer handshake and stored byte
         logic       cap;
         logic       in_rdy;
         logic       out_vld;
         logic       out_pop;
         byte_t      out_dat;
         byte_t      hold_r;
         byte_t      hold_nxt;
         logic       ovr_r;
         logic       ovr_nxt;

         //////////////////////////////////////////////////////////////////////
         // Control pins
         always_comb begin
            clk_s_nxt  = {clk_s_r[1:0], clk_pin[d]};
            cen_s_nxt  = {cen_s_r[1:0], cen_pin[d]};
            oe_s_nxt   = {oe_s_r[1:0], oe_pin[d]};
            clk_lv_nxt = agreed(clk_s_r, clk_lv_r);
            cen_lv_nxt = agreed(cen_s_r, cen_lv_r);
            oe_lv_nxt  = agreed(oe_s_r, oe_lv_r);
         end

         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               clk_s_r  <= SYNC_RST;
               cen_s_r  <= SYNC_RST_HI;
               oe_s_r   <= SYNC_RST_HI;
               clk_lv_r <= 1'b0;
               cen_lv_r <= 1'b1;
               oe_lv_r  <= 1'b1;
            end else begin
               clk_s_r  <= clk_s_nxt;
               cen_s_r  <= cen_s_nxt;
               oe_s_r   <= oe_s_nxt;
               clk_lv_r <= clk_lv_nxt;
               cen_lv_r <= cen_lv_nxt;
               oe_lv_r  <= oe_lv_nxt;
            end
         end

         //////////////////////////////////////////////////////////////////////
         // Source data delay line
         always_comb begin
            dat_s1_nxt = src_pin[d];
            dat_s2_nxt = dat_s1_r;
            dat_s3_nxt = dat_s2_r;
         end

         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               dat_s1_r <= DATA_RST;
               dat_s2_r <= DATA_RST;
               dat_s3_r <= DATA_RST;
            end else begin
               dat_s1_r <= dat_s1_nxt;
               dat_s2_r <= dat_s2_nxt;
               dat_s3_r <= dat_s3_nxt;
            end
         end

         //////////////////////////////////////////////////////////////////////
         // The filtered clock level is only real once the synchroniser has
         // been refilled; without this a clock pin resting high across a
         // reset release would be taken for a rising edge
         always_comb begin
            settle_nxt = settle_r;
            if (settle_r != SETTLE_END) begin
               settle_nxt = settle_r + 2'h1;
            end
            armed_nxt = (settle_r == SETTLE_END);
         end

         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               settle_r <= SETTLE_RST;
               armed_r  <= 1'b0;
            end else begin
               settle_r <= settle_nxt;
               armed_r  <= armed_nxt;
            end
         end

         //////////////////////////////////////////////////////////////////////
         // Clock, enable and data leave their synchronisers in step, so the
         // enable keeps the setup and hold that it had at the pins
         assign cap = armed_r && clk_lv_nxt && !clk_lv_r && !cen_lv_nxt;

         // Two-entry buffer between the capture strobe and the hold register

         xcvr_buf u_buf (
            .core_clk_i  (core_clk_i),
            .nrst_i      (nrst_i),
            .in_valid_i  (cap),
            .in_data_i   (dat_s3_r),
            .in_ready_o  (in_rdy),
            .out_valid_o (out_vld),
            .out_data_o  (out_dat),
            .out_ready_i (1'b1)
         );
         // The hold register takes every word, so the buffer never stalls
         assign out_pop = out_vld;

         //////////////////////////////////////////////////////////////////////
         // Stored byte; overrun is sticky and marks a capture that found
         // the buffer full and was therefore lost
         always_comb begin
            hold_nxt = hold_r;
            ovr_nxt  = ovr_r;
            if (out_pop) begin
               hold_nxt = out_dat;
            end
            if (cap && !in_rdy) begin
               ovr_nxt = 1'b1;
            end
         end

         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               hold_r <= DATA_RST;
               ovr_r  <= 1'b0;
            end else begin
               hold_r <= hold_nxt;
               ovr_r  <= ovr_nxt;
            end
         end

         assign dst_q[d]  = hold_r;
         assign dst_oe[d] = !oe_lv_r;
         assign ovr[d]    = ovr_r;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Enables are never forced on; the outside bus owner must release first
   // Every bit of a port shares its direction's enable
   assign port_b_o         = dst_q[0];
   assign port_b_oe_o      = {BUS_W{dst_oe[0]}};
   assign port_a_o         = dst_q[1];
   assign port_a_oe_o      = {BUS_W{dst_oe[1]}};
   assign a_to_b_overrun_o = ovr[0];
   assign b_to_a_overrun_o = ovr[1];
endmodule

/* File: logic/xcvr_pkg.sv */
// Constants and types shared by the registered bus transceiver
package xcvr_pkg;
   localparam int unsigned BUS_W         = 8;
   localparam logic [7:0]  DATA_RST      = 8'h00;
   localparam int unsigned BUF_DEPTH     = 2;
   localparam int unsigned SYNC_STAGES   = 3;
   localparam logic [2:0]  SYNC_RST      = 3'h0;
   localparam logic [2:0]  SYNC_RST_HI   = 3'h7;
   localparam logic [1:0]  SETTLE_RST    = 2'h0;
   // Cycles after reset until the clock synchroniser holds real pin samples
   localparam logic [1:0]  SETTLE_END    = 2'h3;
   typedef logic [BUS_W-1:0] byte_t;
endpackage

/* File: logic/xcvr_buf.sv */
// Two-entry skid buffer carrying one direction's captured byte to its port
`timescale 1ns/1ps
module xcvr_buf
   import xcvr_pkg::*;
(
   input  wire logic  core_clk_i,
   input  wire logic  nrst_i,
   input  wire logic  in_valid_i,
   input  wire byte_t in_data_i,
   output logic       in_ready_o,
   output logic       out_valid_o,
   output byte_t      out_data_o,
   input  wire logic  out_ready_i
);
   byte_t      mem_r [BUF_DEPTH];
   byte_t      mem_nxt [BUF_DEPTH];
   logic       wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic       push, pop;

   assign in_ready_o  = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data_i;
         wp_nxt        = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mem_r[0] <= DATA_RST;
         mem_r[1] <= DATA_RST;
         wp_r     <= 1'b0;
         rp_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         mem_r <= mem_nxt;
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign out_data_o = mem_r[rp_r];
endmodule

/* File: dv/xcvr_bus_model.sv */
// Far-side bus: outside driver plus wire resolution for one port
`timescale 1ns/1ps
module xcvr_bus_model
   import xcvr_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       ext_en_i,
   input  wire byte_t      ext_i,
   input  wire logic [7:0] oe_i,
   input  wire byte_t      dev_i,
   output byte_t           bus_o
);
   byte_t last_r = 8'h00;
   // A floating bus toggles so it never passes for held data
   assign bus_o = (oe_i & dev_i) | (~oe_i & (ext_en_i ? ext_i : ~last_r));
   always @(posedge clk_i) begin
      last_r <= bus_o;
   end
endmodule

/* File: dv/xcvr_top_chk.sv */
// Port timing assertions for the bus transceiver
`timescale 1ns/1ps
module xcvr_top_chk
   import xcvr_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       nrst_i,
   input wire logic       a_to_b_capture_clock_i,
   input wire logic       a_to_b_capture_enable_n_i,
   input wire logic       a_to_b_drive_enable_n_i,
   input wire logic       b_to_a_capture_clock_i,
   input wire logic       b_to_a_capture_enable_n_i,
   input wire logic       b_to_a_drive_enable_n_i,
   input wire byte_t      port_a_i,
   input wire byte_t      port_b_i,
   input wire byte_t      port_a_o,
   input wire byte_t      port_b_o,
   input wire logic [7:0] port_a_oe_o,
   input wire logic [7:0] port_b_oe_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_b_off; a_to_b_drive_enable_n_i[*5] |-> port_b_oe_o == 8'h00; endproperty
   a_b_off: assert property (p_b_off) else $error("b driven");
   property p_b_on; (!a_to_b_drive_enable_n_i)[*5] |-> port_b_oe_o == 8'hff; endproperty
   a_b_on: assert property (p_b_on) else $error("b idle");
   property p_a_off; b_to_a_drive_enable_n_i[*5] |-> port_a_oe_o == 8'h00; endproperty
   a_a_off: assert property (p_a_off) else $error("a driven");
   property p_a_on; (!b_to_a_drive_enable_n_i)[*5] |-> port_a_oe_o == 8'hff; endproperty
   a_a_on: assert property (p_a_on) else $error("a idle");
   property p_ab_cap; $rose(a_to_b_capture_clock_i) && !a_to_b_capture_enable_n_i
      |-> ##6 port_b_o == $past(port_a_i, 6); endproperty
   a_ab_cap: assert property (p_ab_cap) else $error("ab capture");
   property p_ba_cap; $rose(b_to_a_capture_clock_i) && !b_to_a_capture_enable_n_i
      |-> ##6 port_a_o == $past(port_b_i, 6); endproperty
   a_ba_cap: assert property (p_ba_cap) else $error("ba capture");
   property p_ab_hold; $stable(a_to_b_capture_clock_i)[*8] |-> $stable(port_b_o); endproperty
   a_ab_hold: assert property (p_ab_hold) else $error("ab hold");
   property p_ba_hold; $stable(b_to_a_capture_clock_i)[*8] |-> $stable(port_a_o); endproperty
   a_ba_hold: assert property (p_ba_hold) else $error("ba hold");
   property p_ab_gate; a_to_b_capture_enable_n_i[*8] |-> $stable(port_b_o); endproperty
   a_ab_gate: assert property (p_ab_gate) else $error("ab gate");
endmodule
bind xcvr_top xcvr_top_chk chk (.*);

/* File: dv/xcvr_top_tb.sv */
// Self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
`define CHK(n, e, g) cmp_count++; \
   if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, g); end
module xcvr_top_tb;
   import xcvr_pkg::*;
   logic       clk = 1'b0, nrst_n = 1'b0, ea_en = 1'b1, eb_en = 1'b1;
   logic       ab_ck = 1'b0, ab_en = 1'b1, ab_oe = 1'b1, ba_ck = 1'b0, ba_en = 1'b1;
   logic       ba_oe = 1'b1;
   logic       ab_ovr, ba_ovr;
   logic [7:0] a_oe, b_oe;
   byte_t      ea = 8'h00, eb = 8'h00, a_o, b_o, bus_a, bus_b;
   int         n_errors = 0, cmp_count = 0, cyc = 0;
   always #5 clk = ~clk;
   xcvr_top dut (.core_clk_i(clk), .nrst_i(nrst_n), .a_to_b_capture_clock_i(ab_ck),
      .a_to_b_capture_enable_n_i(ab_en), .a_to_b_drive_enable_n_i(ab_oe),
      .b_to_a_capture_clock_i(ba_ck), .b_to_a_capture_enable_n_i(ba_en),
      .b_to_a_drive_enable_n_i(ba_oe), .port_a_i(bus_a), .port_a_o(a_o), .port_a_oe_o(a_oe),
      .port_b_i(bus_b), .port_b_o(b_o), .port_b_oe_o(b_oe), .a_to_b_overrun_o(ab_ovr),
      .b_to_a_overrun_o(ba_ovr));
   xcvr_bus_model m_a (.clk_i(clk), .ext_en_i(ea_en), .ext_i(ea), .oe_i(a_oe), .dev_i(a_o),
      .bus_o(bus_a));
   xcvr_bus_model m_b (.clk_i(clk), .ext_en_i(eb_en), .ext_i(eb), .oe_i(b_oe), .dev_i(b_o),
      .bus_o(bus_b));
   task automatic close_out;
      $display("Comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Ceiling far above the roughly 125 cycles the run needs
   always @(posedge clk) if (++cyc == 2000) begin n_errors++; close_out(); end
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Pins held at least 3 cycles so the synchronisers see every level
   task automatic pulse(input bit ba, input byte_t d);
      if (ba) eb = d; else ea = d;
      step(3);
      if (ba) ba_ck = 1'b1; else ab_ck = 1'b1;
      step(4);
      ab_ck = 1'b0;
      ba_ck = 1'b0;
      step(4);
   endtask
   task automatic t_ab_pass;
      ab_en = 1'b0;
      pulse(0, 8'ha5);
      eb_en = 1'b0;
      step(1);
      ab_oe = 1'b0;
      step(6);
      `CHK("port_b_o", 8'ha5, b_o)
      `CHK("port_b_oe_o", 8'hff, b_oe)
      pulse(0, 8'h5a);
      `CHK("bus_b", 8'h5a, bus_b)
   endtask
   task automatic t_ab_gate;
      ab_en = 1'b1;
      pulse(0, 8'h3c);
      `CHK("port_b_o", 8'h5a, b_o)
      ab_ck = 1'b1;
      step(4);
      ab_en = 1'b0;
      ea = 8'hc3;
      step(8);
      `CHK("port_b_o", 8'h5a, b_o)
      ab_ck = 1'b0;
      ab_oe = 1'b1;
      step(6);
      `CHK("port_b_oe_o", 8'h00, b_oe)
      eb_en = 1'b1;
   endtask
   task automatic t_ba;
      ba_en = 1'b0;
      pulse(1, 8'h96);
      ea_en = 1'b0;
      step(1);
      ba_oe = 1'b0;
      step(6);
      `CHK("bus_a", 8'h96, bus_a)
      `CHK("port_b_o", 8'h5a, b_o)
   endtask
   // A clock pin resting high across a reset release is no rising edge
   task automatic t_reset;
      ba_oe = 1'b1;
      ab_en = 1'b1;
      step(3);
      ab_ck = 1'b1;
      step(6);
      nrst_n = 1'b0;
      ab_en = 1'b0;
      step(2);
      `CHK("port_b_o", DATA_RST, b_o)
      `CHK("port_a_o", DATA_RST, a_o)
      nrst_n = 1'b1;
      step(10);
      `CHK("port_b_o", DATA_RST, b_o)
      `CHK("a_to_b_overrun_o", 1'b0, ab_ovr)
      `CHK("b_to_a_overrun_o", 1'b0, ba_ovr)
      ea_en = 1'b1;
      ab_ck = 1'b0;
      step(4);
   endtask
   initial begin
      step(20);
      nrst_n = 1'b1;
      step(4);
      t_ab_pass();
      t_ab_gate();
      t_ba();
      t_reset();
      close_out();
   end
endmodule
